//--- drt_timer.sv
// dual reload down timer: i/o register port, control register, shared output pin
// assumes i/o strobes are synchronous one-cycle pulses on clk_in (20 MHz)
`timescale 1ns/10ps
`default_nettype none
module drt_timer
   import drt_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic [7:0] io_addr_in,
   input  wire logic [7:0] io_wdata_in,
   input  wire logic       io_rd_in,
   input  wire logic       io_wr_in,
   input  wire logic       addr_bit_in,
   output logic      [7:0] io_rdata_out,
   output logic            irq_ch0_out,
   output logic            irq_ch1_out,
   output logic            shared_pin_out
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] pre;
      logic [7:0] ctrl;
      logic [1:0] armed;     // control register seen with flag set, per channel
      logic       timer_out_pin;
      logic [7:0] rdata;
      logic [1:0] irq;
      logic       pin;
   } drt_state_t;
   drt_state_t st_q;
   drt_state_t st_d;
   drt_io_t    io;
   logic       tick;
   logic [1:0] zero;
   // channel views: live count, reload value, held high byte
   logic [15:0] cnt0;
   logic [15:0] cnt1;
   logic [15:0] rld0;
   logic [15:0] rld1;
   logic [7:0]  held0;
   logic [7:0]  held1;
   // decoded one-cycle strobes
   logic        rd_c0l;
   logic        rd_c0h;
   logic        rd_c1l;
   logic        rd_c1h;
   logic        rd_ctl;
   logic        wr_ctl;
   // bundle the port so the decode reads one struct
   assign io = '{addr:  io_addr_in,
                 wdata: io_wdata_in,
                 rd:    io_rd_in,
                 wr:    io_wr_in};
   // shared divide by twenty, one tick for both channels
   assign tick = (st_q.pre == DRT_PRE_LAST);
   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   // the divider is five bits wide, so the prescale must fit in it
   if (DRT_PRESCALE < 2 || DRT_PRESCALE > 32)
   begin : g_prescale_check
      $error("prescale does not fit the five-bit divider");
   end
   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   assign rd_c0l = io.rd && (io.addr == DRT_OFF_CNT0_LO);
   assign rd_c0h = io.rd && (io.addr == DRT_OFF_CNT0_HI);
   assign rd_c1l = io.rd && (io.addr == DRT_OFF_CNT1_LO);
   assign rd_c1h = io.rd && (io.addr == DRT_OFF_CNT1_HI);
   assign rd_ctl = io.rd && (io.addr == DRT_OFF_CTRL);
   assign wr_ctl = io.wr && (io.addr == DRT_OFF_CTRL);
   // -----------------------------------------------------------------
   // channels
   // -----------------------------------------------------------------
   // channel 0 has no output function of its own
   drt_channel u_ch0 (
      .clk_in       (clk_in),
      .nrst_in      (nrst_in),
      .tick_in      (tick),
      .enable_in    (st_q.ctrl[DRT_BIT_CEN0]),
      .wr_cnt_lo_in (io.wr && (io.addr == DRT_OFF_CNT0_LO)),
      .wr_cnt_hi_in (io.wr && (io.addr == DRT_OFF_CNT0_HI)),
      .wr_rld_lo_in (io.wr && (io.addr == DRT_OFF_RLD0_LO)),
      .wr_rld_hi_in (io.wr && (io.addr == DRT_OFF_RLD0_HI)),
      .rd_cnt_lo_in (rd_c0l),
      .wdata_in     (io.wdata),
      .count_out    (cnt0),
      .reload_out   (rld0),
      .held_hi_out  (held0),
      .zero_out     (zero[0])
   );
   // channel 1 also steers the shared pin through zero[1]
   drt_channel u_ch1 (
      .clk_in       (clk_in),
      .nrst_in      (nrst_in),
      .tick_in      (tick),
      .enable_in    (st_q.ctrl[DRT_BIT_CEN1]),
      .wr_cnt_lo_in (io.wr && (io.addr == DRT_OFF_CNT1_LO)),
      .wr_cnt_hi_in (io.wr && (io.addr == DRT_OFF_CNT1_HI)),
      .wr_rld_lo_in (io.wr && (io.addr == DRT_OFF_RLD1_LO)),
      .wr_rld_hi_in (io.wr && (io.addr == DRT_OFF_RLD1_HI)),
      .rd_cnt_lo_in (rd_c1l),
      .wdata_in     (io.wdata),
      .count_out    (cnt1),
      .reload_out   (rld1),
      .held_hi_out  (held1),
      .zero_out     (zero[1])
   );
   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   // one combinational pass builds the whole next state
   always_comb
   begin
      st_d = st_q;
      st_d.pre = tick ? 5'h00 : st_q.pre + 5'h01;
      // ------------------------------------------------------------
      // control register and flags
      // ------------------------------------------------------------
      // software owns bits 5..0; flags stay hardware-only
      if (wr_ctl)
         st_d.ctrl[5:0] = io.wdata[5:0];
      // per-channel arming: a status read only arms channels whose flag is up
      if (rd_ctl)
         st_d.armed = st_q.armed |
                      {st_q.ctrl[DRT_BIT_FLAG1], st_q.ctrl[DRT_BIT_FLAG0]};
      // counter byte read after status read clears that channel only
      if (st_q.armed[0] && (rd_c0l || rd_c0h))
      begin
         st_d.ctrl[DRT_BIT_FLAG0] = 1'b0;
         st_d.armed[0] = 1'b0;
      end
      if (st_q.armed[1] && (rd_c1l || rd_c1h))
      begin
         st_d.ctrl[DRT_BIT_FLAG1] = 1'b0;
         st_d.armed[1] = 1'b0;
      end
      // a zero event in the clearing cycle wins over the clear
      if (zero[0]) st_d.ctrl[DRT_BIT_FLAG0] = 1'b1;
      if (zero[1]) st_d.ctrl[DRT_BIT_FLAG1] = 1'b1;
      // ------------------------------------------------------------
      // shared pin
      // ------------------------------------------------------------
      // a write that leaves bits 3..2 alone must not undo a toggle
      // output level: programmed level until first zero, then action on zero
      if (wr_ctl && (io.wdata[3:2] != st_q.ctrl[3:2]))
      begin
         if (io.wdata[3:2] == DRT_OC_HIGH) st_d.timer_out_pin = 1'b1;
         else if (io.wdata[3:2] == DRT_OC_LOW) st_d.timer_out_pin = 1'b0;
      end
      else if (zero[1])
      begin
         case (st_q.ctrl[3:2])
            DRT_OC_TOGGLE: st_d.timer_out_pin = ~st_q.timer_out_pin;
            DRT_OC_LOW:    st_d.timer_out_pin = 1'b0;
            DRT_OC_HIGH:   st_d.timer_out_pin = 1'b1;
            default:       st_d.timer_out_pin = st_q.timer_out_pin;
         endcase
      end
      // pin mux registered so the output comes from a flop
      st_d.pin = (st_d.ctrl[3:2] == DRT_OC_ADDR) ? addr_bit_in : st_d.timer_out_pin;
      // requests use the next flags so they rise with them, not a cycle late
      st_d.irq[0] = st_d.ctrl[DRT_BIT_FLAG0] && st_d.ctrl[DRT_BIT_IEN0];
      st_d.irq[1] = st_d.ctrl[DRT_BIT_FLAG1] && st_d.ctrl[DRT_BIT_IEN1];
      // ------------------------------------------------------------
      // read data
      // ------------------------------------------------------------
      // unmapped offsets answer zero; no read leaves the last value standing
      if (rd_c0l)      st_d.rdata = cnt0[7:0];
      else if (rd_c0h) st_d.rdata = held0;
      else if (rd_c1l) st_d.rdata = cnt1[7:0];
      else if (rd_c1h) st_d.rdata = held1;
      else if (rd_ctl) st_d.rdata = st_q.ctrl;
      else if (io.rd && io.addr == DRT_OFF_RLD0_LO) st_d.rdata = rld0[7:0];
      else if (io.rd && io.addr == DRT_OFF_RLD0_HI) st_d.rdata = rld0[15:8];
      else if (io.rd && io.addr == DRT_OFF_RLD1_LO) st_d.rdata = rld1[7:0];
      else if (io.rd && io.addr == DRT_OFF_RLD1_HI) st_d.rdata = rld1[15:8];
      else if (io.rd)  st_d.rdata = 8'h00;
   end
   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // synchronous reset; every output flop clears with the state
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         st_q.pre   <= 5'h00;
         st_q.ctrl  <= DRT_CTRL_RESET;
         st_q.armed <= 2'h0;
         st_q.timer_out_pin  <= 1'b0;
         st_q.rdata <= 8'h00;
         st_q.irq   <= 2'h0;
         st_q.pin   <= 1'b0; // address function after reset
      end
      else
         st_q <= st_d;
   end
   // -----------------------------------------------------------------
   // outputs, each straight from a flop
   // -----------------------------------------------------------------
   assign io_rdata_out   = st_q.rdata;
   assign irq_ch0_out    = st_q.irq[0];
   assign irq_ch1_out    = st_q.irq[1];
   assign shared_pin_out = st_q.pin;
endmodule : drt_timer
`default_nettype wire

//--- drt_pkg.sv
// package for the dual reload down timer: offsets, fields, reset values, timing
// assumes an 8-bit processor i/o port with one-cycle read and write strobes
package drt_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] DRT_OFF_CNT0_LO = 8'h0c;
   localparam logic [7:0] DRT_OFF_CNT0_HI = 8'h0d;
   localparam logic [7:0] DRT_OFF_RLD0_LO = 8'h0e;
   localparam logic [7:0] DRT_OFF_RLD0_HI = 8'h0f;
   localparam logic [7:0] DRT_OFF_CTRL    = 8'h10;
   localparam logic [7:0] DRT_OFF_CNT1_LO = 8'h14;
   localparam logic [7:0] DRT_OFF_CNT1_HI = 8'h15;
   localparam logic [7:0] DRT_OFF_RLD1_LO = 8'h16;
   localparam logic [7:0] DRT_OFF_RLD1_HI = 8'h17;
   // -----------------------------------------------------------------
   // control register fields
   // -----------------------------------------------------------------
   localparam int DRT_BIT_FLAG1 = 7;
   localparam int DRT_BIT_FLAG0 = 6;
   localparam int DRT_BIT_IEN1  = 5;
   localparam int DRT_BIT_IEN0  = 4;
   localparam int DRT_BIT_OC_HI = 3;
   localparam int DRT_BIT_OC_LO = 2;
   localparam int DRT_BIT_CEN1  = 1;
   localparam int DRT_BIT_CEN0  = 0;
   localparam logic [7:0]  DRT_CTRL_RESET  = 8'h00;
   localparam logic [15:0] DRT_COUNT_RESET = 16'hffff;
   localparam logic [15:0] DRT_COUNT_ZERO  = 16'h0000;
   // output control encodings
   localparam logic [1:0] DRT_OC_ADDR   = 2'h0;
   localparam logic [1:0] DRT_OC_TOGGLE = 2'h1;
   localparam logic [1:0] DRT_OC_LOW    = 2'h2;
   localparam logic [1:0] DRT_OC_HIGH   = 2'h3;
   // -----------------------------------------------------------------
   // timing: prescale of the system clock
   // -----------------------------------------------------------------
   localparam int DRT_PRESCALE = 20;
   localparam logic [4:0] DRT_PRE_LAST = 5'(DRT_PRESCALE - 1);
   // i/o access bundle
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       rd;
      logic       wr;
   } drt_io_t;
endpackage : drt_pkg

//--- drt_channel.sv
// one timer channel: down counter, reload value, high-byte read holding register
// assumes the top decodes the i/o port into per-channel byte strobes
`timescale 1ns/10ps
`default_nettype none
module drt_channel
   import drt_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        tick_in,
   input  wire logic        enable_in,
   input  wire logic        wr_cnt_lo_in,
   input  wire logic        wr_cnt_hi_in,
   input  wire logic        wr_rld_lo_in,
   input  wire logic        wr_rld_hi_in,
   input  wire logic        rd_cnt_lo_in,
   input  wire logic [7:0]  wdata_in,
   output logic      [15:0] count_out,
   output logic      [15:0] reload_out,
   output logic      [7:0]  held_hi_out,
   output logic             zero_out
);
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic [7:0]  held_hi;
   } drt_ch_state_t;
   drt_ch_state_t st_q;
   drt_ch_state_t st_d;
   logic          step;
   // the counter only steps on a prescale tick while enabled
   assign step = tick_in && enable_in;
   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      zero_out = 1'b0;
      if (step)
      begin
         if (st_q.count == DRT_COUNT_ZERO)
            st_d.count = st_q.reload;
         else
            st_d.count = st_q.count - 16'h0001;
         zero_out = (st_q.count == 16'h0001); // decrement reaches zero
      end
      // software writes win; they are only legal with counting halted
      if (wr_cnt_lo_in) st_d.count[7:0]   = wdata_in;
      if (wr_cnt_hi_in) st_d.count[15:8]  = wdata_in;
      if (wr_rld_lo_in) st_d.reload[7:0]  = wdata_in;
      if (wr_rld_hi_in) st_d.reload[15:8] = wdata_in;
      // latch high half so a later high read is coherent
      if (rd_cnt_lo_in) st_d.held_hi = st_q.count[15:8];
   end
   // synchronous reset: counter and reload come up all ones
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         st_q.count   <= DRT_COUNT_RESET;
         st_q.reload  <= DRT_COUNT_RESET;
         st_q.held_hi <= DRT_COUNT_RESET[15:8];
      end
      else
         st_q <= st_d;
   end
   assign count_out   = st_q.count;
   assign reload_out  = st_q.reload;
   assign held_hi_out = st_q.held_hi;
endmodule : drt_channel
`default_nettype wire

//--- drt_timer_assertions.sv
// port checker for the dual reload down timer
// assumes a bind from the bench top file
`timescale 1ns/10ps
`default_nettype none
module drt_timer_assertions
   import drt_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic [7:0] io_addr_in,
   input  wire logic [7:0] io_wdata_in,
   input  wire logic       io_rd_in,
   input  wire logic       io_wr_in,
   input  wire logic       addr_bit_in,
   input  wire logic [7:0] io_rdata_out,
   input  wire logic       irq_ch0_out,
   input  wire logic       irq_ch1_out,
   input  wire logic       shared_pin_out
);
   // -------------------------------------------------------------
   // shadow of the writable control bits
   // -------------------------------------------------------------
   logic [5:0] ctl_q;
   wire logic  ctl_wr = io_wr_in && (io_addr_in == DRT_OFF_CTRL);
   // flags are not shadowed: they depend on the hidden counters
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         ctl_q <= 6'h00;
      else if (ctl_wr)
         ctl_q <= io_wdata_in[5:0];
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence ctl_rd_s;
      io_rd_in && (io_addr_in == DRT_OFF_CTRL);
   endsequence
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   reset_clear_a: assert property (disable iff (1'b0) !nrst_in |=>
      !irq_ch0_out && !irq_ch1_out && !shared_pin_out && io_rdata_out == 8'h00)
      else $error("outputs not cleared by reset");
   ctl_read_a: assert property (ctl_rd_s |=> io_rdata_out[5:0] == $past(ctl_q))
      else $error("control readback wrong");
   data_hold_a: assert property (!io_rd_in |=> $stable(io_rdata_out))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (io_rd_in && io_addr_in == 8'h11 |=>
      io_rdata_out == 8'h00) else $error("unmapped read not zero");
   addr_pass_a: assert property (ctl_q[3:2] == DRT_OC_ADDR && !ctl_wr |=>
      shared_pin_out == $past(addr_bit_in)) else $error("pin not address bit");
   force_level_a: assert property (ctl_q[3] && $stable(ctl_q) |->
      shared_pin_out == ctl_q[2]) else $error("forced pin level wrong");
   irq0_gate_a: assert property (irq_ch0_out |-> ctl_q[4])
      else $error("ch0 request without enable");
   irq1_gate_a: assert property (irq_ch1_out |-> ctl_q[5])
      else $error("ch1 request without enable");
endmodule // drt_timer_assertions
`default_nettype wire

//--- dual_reload_down_timer_tb.sv
// self-checking bench for the dual reload down timer
// assumes drt_pkg and the checker file are compiled first
`timescale 1ns/10ps
`default_nettype none
module dual_reload_down_timer_tb
   import drt_pkg::*;
;
   logic       clk_in = 1'b0;
   logic       nrst_in = 1'b0;
   logic       rd = 1'b0;
   logic       wr = 1'b0;
   logic       abit = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] v;
   logic [7:0] rdat;
   logic       irq0, irq1, pin;
   logic [7:0] offs [8] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h14, 8'h15, 8'h16, 8'h17};
   logic [7:0] val [8];
   int         errors = 0, checks_done = 0, cyc = 0, t1, s;
   // 50 ns clock and cycle stamp
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;
   drt_timer DUT (.clk_in(clk_in), .nrst_in(nrst_in), .io_addr_in(adr), .io_wdata_in(wd),
      .io_rd_in(rd), .io_wr_in(wr), .addr_bit_in(abit), .io_rdata_out(rdat),
      .irq_ch0_out(irq0), .irq_ch1_out(irq1), .shared_pin_out(pin));
   // -------------------------------------------------------------
   // helpers: compare, port write, port read, event wait
   // -------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // event spacing for a number of prescaled steps
   function automatic logic [15:0] exp_period(input int steps);
      return 16'(steps * DRT_PRESCALE);
   endfunction
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      adr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk_in);
      wr = 1'b0;
   endtask
   // data is taken a full cycle late, it stands until the next read
   task automatic rreg(input logic [7:0] a);
      @(negedge clk_in);
      adr = a;
      rd = 1'b1;
      @(negedge clk_in);
      rd = 1'b0;
      @(negedge clk_in);
      v = rdat;
   endtask
   // a wait that runs out of cycles counts as a mismatch
   task automatic wait_ev(input bit on_pin);
      logic p;
      int   n;
      p = pin;
      n = 0;
      while (n < 100 && (on_pin ? pin === p : irq0 !== 1'b1))
      begin
         @(negedge clk_in);
         n++;
      end
      t1 = cyc;
      chk(16'(n / 100), 16'h0000, "event wait limit");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // watchdog: tests need well under 20000 cycles
   initial
   begin
      #1000000;
      errors++;
      end_of_test();
   end
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial
   begin
      void'($urandom(32'hbff0));
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      nrst_in = 1'b1;
      foreach (offs[i])
      begin
         rreg(offs[i]);
         chk(v, 8'hff, "reset byte");
      end
      rreg(DRT_OFF_CTRL);
      chk(v, DRT_CTRL_RESET, "reset control");
      rreg(8'h11);
      chk(v, 8'h00, "unmapped read");
      $display("test reset done");
      // all bytes written first: a low read would latch a stale high byte
      foreach (offs[i])
      begin
         val[i] = 8'($urandom);
         wreg(offs[i], val[i]);
      end
      foreach (offs[i])
      begin
         rreg(offs[i]);
         chk(v, val[i], "byte rw");
      end
      wreg(8'h0d, 8'h5a);
      rreg(8'h0c);
      wreg(8'h0d, 8'ha5);
      rreg(8'h0d);
      chk(v, 8'h5a, "held high byte");
      $display("test registers done");
      wreg(DRT_OFF_CTRL, 8'hcc);
      @(negedge clk_in);
      chk(pin, 1'b1, "forced high");
      rreg(DRT_OFF_CTRL);
      chk(v, 8'h0c, "flags read only");
      wreg(DRT_OFF_CTRL, 8'h08);
      @(negedge clk_in);
      chk(pin, 1'b0, "forced low");
      wreg(DRT_OFF_CTRL, 8'h00);
      repeat (8)
      begin
         @(negedge clk_in);
         abit = 1'($urandom);
         @(negedge clk_in);
         chk(pin, abit, "address pass");
      end
      $display("test pin modes done");
      wreg(8'h0e, 8'h02);
      wreg(8'h0f, 8'h00);
      wreg(8'h0c, 8'h02);
      wreg(8'h0d, 8'h00);
      wreg(DRT_OFF_CTRL, 8'h11);
      wait_ev(1'b0);
      s = t1;
      rreg(DRT_OFF_CTRL);
      chk(v[6], 1'b1, "ch0 flag set");
      rreg(8'h0c);
      chk(v, 8'h00, "count at zero");
      chk(irq0, 1'b0, "flag cleared");
      wait_ev(1'b0);
      chk(16'(t1 - s), exp_period(3), "reload period");
      wreg(DRT_OFF_CTRL, 8'h01);
      @(negedge clk_in);
      chk(irq0, 1'b0, "request masked");
      rreg(DRT_OFF_CTRL);
      chk(v, 8'h41, "flag kept");
      rreg(DRT_OFF_CNT1_LO);
      rreg(DRT_OFF_CTRL);
      chk(v[6], 1'b1, "other channel read keeps flag");
      wreg(DRT_OFF_CTRL, 8'h00);
      rreg(8'h0c);
      val[0] = v;
      repeat (50) @(negedge clk_in);
      rreg(8'h0c);
      chk(v, val[0], "stopped hold");
      $display("test channel 0 done");
      wreg(8'h16, 8'h01);
      wreg(8'h17, 8'h00);
      wreg(8'h14, 8'h01);
      wreg(8'h15, 8'h00);
      wreg(DRT_OFF_CTRL, 8'h26);
      wait_ev(1'b1);
      s = t1;
      wait_ev(1'b1);
      chk(16'(t1 - s), exp_period(2), "toggle period");
      chk(irq1, 1'b1, "ch1 request");
      $display("test toggle done");
      end_of_test();
   end
endmodule // dual_reload_down_timer_tb
bind drt_timer drt_timer_assertions CHK (.clk_in(clk_in), .nrst_in(nrst_in),
   .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_rd_in(io_rd_in),
   .io_wr_in(io_wr_in), .addr_bit_in(addr_bit_in), .io_rdata_out(io_rdata_out),
   .irq_ch0_out(irq_ch0_out), .irq_ch1_out(irq_ch1_out), .shared_pin_out(shared_pin_out));
`default_nettype wire
